// File: rtl/irq_flags_regs.vh
// Register indices, field layouts and reset values of the request flag bank
`ifndef IRQ_FLAGS_REGS_VH
`define IRQ_FLAGS_REGS_VH

// Register indices; the byte address is four times the index
`define IDX_W            16
`define IDX_FLAGS_45     16'hf02c
`define IDX_FLAGS_67     16'hf02e
`define IDX_FLAGS_7      16'hf02f
`define IDX_SET_45       16'hf030
`define IDX_CLR_45       16'hf031
`define IDX_SET_67       16'hf032
`define IDX_CLR_67       16'hf033
`define IDX_INT_STATUS   16'hf034
`define IDX_INT_MASK     16'hf035

// Flag positions in the groups 4/5 word
`define BIT_TIMER_FOUR   14
`define BIT_UART_CH21    9
`define BIT_UART_CH20    8
`define BIT_TIMER_THREE  7
`define BIT_TIMER_TWO    6
`define BIT_UART_CH11    2
`define BIT_UART_CH10    1
`define BIT_I2C_ZERO     0

// Flag positions in the groups 6/7 word
`define BIT_SLOW_TB_TWO   13
`define BIT_SLOW_TB_ONE   12
`define BIT_SLOW_TB_THREE 11
`define BIT_SLOW_TB_ZERO  10
`define BIT_TIMER_X       9

// Implemented flag positions
`define IMPL_45          16'h43c7
`define IMPL_67          16'h3e00

// Reset values
`define FLAGS_RESET      16'h0000
`define INT_RESET        3'h0

// Interrupt status layout
`define EVT_W            3
`define EVT_PEND_45      0
`define EVT_PEND_67      1
`define EVT_OVERRUN      2

`endif

// File: rtl/request_flag_bit.v
// One interrupt request flag with hardware set, software access and accept clear
`timescale 1ns/1ps
module request_flag_bit
#(
   parameter IMPL = 1
)
(
   input  wire pclk,
   input  wire presetn,
   input  wire clk_en,
   input  wire hw_set,
   input  wire sw_write,
   input  wire sw_wdata,
   input  wire sw_set,
   input  wire sw_clr,
   input  wire accept,
   output wire flag_d,
   output reg  flag_q,
   output wire overrun
);

   wire set_term;
   wire clr_term;

   // Peripheral request sets regardless of enables
   // Writing one sets, same as a peripheral request
   assign set_term = hw_set | sw_set | (sw_write & sw_wdata);
   // Accept by the CPU clears the flag
   assign clr_term = accept | sw_clr | (sw_write & ~sw_wdata);

   // Set wins over any clear; absent flags stay zero
   assign flag_d  = (IMPL == 0) ? 1'b0 :
                    set_term    ? 1'b1 :
                    clr_term    ? 1'b0 : flag_q;
   assign overrun = (IMPL != 0) & hw_set & flag_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= 1'b0;
      end
      else if (clk_en)
      begin
         flag_q <= flag_d;
      end
   end

endmodule // request_flag_bit

// File: rtl/request_flags_bank.v
// Interrupt request flag bank for groups 4 to 7 with APB registers
`timescale 1ns/1ps
`include "irq_flags_regs.vh"
module request_flags_bank
#(
   parameter ADDR_W     = 18,
   parameter PRESENT_45 = 16'hffff,
   parameter PRESENT_67 = 16'hffff
)
(
   input  wire              pclk,
   input  wire              presetn,
   input  wire              clk_en,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire              timer_four_request,
   input  wire              uart_ch21_request,
   input  wire              uart_ch20_request,
   input  wire              timer_three_request,
   input  wire              timer_two_request,
   input  wire              uart_ch11_request,
   input  wire              uart_ch10_request,
   input  wire              i2c_unit_zero_request,
   input  wire              slow_timebase_two_request,
   input  wire              slow_timebase_one_request,
   input  wire              slow_timebase_three_request,
   input  wire              slow_timebase_zero_request,
   input  wire              timer_x_request,
   input  wire [15:0]       source_enable_groups_4_5,
   input  wire [15:0]       source_enable_groups_6_7,
   input  wire [15:0]       accept_groups_4_5,
   input  wire [15:0]       accept_groups_6_7,
   output wire [15:0]       request_flags_groups_4_5,
   output wire [15:0]       request_flags_groups_6_7,
   output reg  [15:0]       pending_groups_4_5,
   output reg  [15:0]       pending_groups_6_7,
   output reg               irq
);

   localparam [15:0] EFF_45 = `IMPL_45 & PRESENT_45;
   localparam [15:0] EFF_67 = `IMPL_67 & PRESENT_67;
   localparam [31:0] EFF_ALL = {EFF_67, EFF_45};

   // Peripheral requests placed at their flag positions
   reg  [15:0]             hw_45;
   reg  [15:0]             hw_67;

   // Bus decode
   wire [`IDX_W-1:0]       idx;
   wire                    sel_flags_45;
   wire                    sel_flags_67;
   wire                    sel_flags_7;
   wire                    sel_set_45;
   wire                    sel_clr_45;
   wire                    sel_set_67;
   wire                    sel_clr_67;
   wire                    sel_status;
   wire                    sel_mask;
   wire                    mapped;
   wire                    access_first;
   wire                    wr_fire;

   // Per-flag software strobes, groups 4/5 low half, 6/7 high half
   wire [31:0]             hw_all;
   wire [31:0]             accept_all;
   wire [31:0]             wr_en_all;
   wire [31:0]             wr_data_all;
   wire [31:0]             set_all;
   wire [31:0]             clr_all;
   wire [31:0]             flag_d_all;
   wire [31:0]             flag_q_all;
   wire [31:0]             overrun_all;

   wire [15:0]             wr_en_67;
   wire [15:0]             wr_data_67;
   wire [15:0]             pend_45_d;
   wire [15:0]             pend_67_d;

   // Interrupt status and mask
   reg  [`EVT_W-1:0]       status_q;
   reg  [`EVT_W-1:0]       mask_q;
   wire [`EVT_W-1:0]       event_vec;
   wire [`EVT_W-1:0]       status_w1c;
   wire [`EVT_W-1:0]       status_d;
   wire [`EVT_W-1:0]       mask_d;

   reg  [31:0]             rdata_d;

   // Place each request at its documented bit
   always @*
   begin
      hw_45                   = 16'h0000;
      hw_45[`BIT_TIMER_FOUR]  = timer_four_request;
      hw_45[`BIT_UART_CH21]   = uart_ch21_request;
      hw_45[`BIT_UART_CH20]   = uart_ch20_request;
      hw_45[`BIT_TIMER_THREE] = timer_three_request;
      hw_45[`BIT_TIMER_TWO]   = timer_two_request;
      hw_45[`BIT_UART_CH11]   = uart_ch11_request;
      hw_45[`BIT_UART_CH10]   = uart_ch10_request;
      hw_45[`BIT_I2C_ZERO]    = i2c_unit_zero_request;
   end

   // Place each request at its documented bit
   always @*
   begin
      hw_67                     = 16'h0000;
      hw_67[`BIT_SLOW_TB_TWO]   = slow_timebase_two_request;
      hw_67[`BIT_SLOW_TB_ONE]   = slow_timebase_one_request;
      hw_67[`BIT_SLOW_TB_THREE] = slow_timebase_three_request;
      hw_67[`BIT_SLOW_TB_ZERO]  = slow_timebase_zero_request;
      hw_67[`BIT_TIMER_X]       = timer_x_request;
   end

   assign idx          = paddr[`IDX_W+1:2];
   assign sel_flags_45 = (idx == `IDX_FLAGS_45);
   assign sel_flags_67 = (idx == `IDX_FLAGS_67);
   assign sel_flags_7  = (idx == `IDX_FLAGS_7);
   assign sel_set_45   = (idx == `IDX_SET_45);
   assign sel_clr_45   = (idx == `IDX_CLR_45);
   assign sel_set_67   = (idx == `IDX_SET_67);
   assign sel_clr_67   = (idx == `IDX_CLR_67);
   assign sel_status   = (idx == `IDX_INT_STATUS);
   assign sel_mask     = (idx == `IDX_INT_MASK);
   assign mapped       = sel_flags_45 | sel_flags_67 | sel_flags_7 |
                         sel_set_45 | sel_clr_45 | sel_set_67 | sel_clr_67 |
                         sel_status | sel_mask;

   // One wait state: first access cycle raises pready, next edge completes
   assign access_first = psel & penable & ~pready;
   assign wr_fire      = clk_en & psel & penable & pready & pwrite & mapped;

   // Byte view of group 7 writes only the upper half of the 6/7 word
   assign wr_en_67   = sel_flags_67 ? 16'hffff :
                       sel_flags_7  ? 16'hff00 : 16'h0000;
   assign wr_data_67 = sel_flags_7 ? {pwdata[7:0], 8'h00} : pwdata[15:0];

   assign hw_all      = {hw_67, hw_45};
   assign accept_all  = {accept_groups_6_7, accept_groups_4_5};
   assign wr_en_all   = {wr_en_67 & {16{wr_fire}}, {16{wr_fire & sel_flags_45}}};
   assign wr_data_all = {wr_data_67, pwdata[15:0]};
   // Bit-set and bit-clear aliases touch only the flags written as one
   assign set_all     = {pwdata[15:0] & {16{wr_fire & sel_set_67}},
                         pwdata[15:0] & {16{wr_fire & sel_set_45}}};
   assign clr_all     = {pwdata[15:0] & {16{wr_fire & sel_clr_67}},
                         pwdata[15:0] & {16{wr_fire & sel_clr_45}}};

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1)
      begin : g_flag
         // Reserved and absent positions are constant zero
         request_flag_bit
         #(
            .IMPL     (EFF_ALL[gi] ? 1 : 0)
         )
         u_flag
         (
            .pclk     (pclk),
            .presetn  (presetn),
            .clk_en   (clk_en),
            .hw_set   (hw_all[gi]),
            .sw_write (wr_en_all[gi]),
            .sw_wdata (wr_data_all[gi]),
            .sw_set   (set_all[gi]),
            .sw_clr   (clr_all[gi]),
            .accept   (accept_all[gi]),
            .flag_d   (flag_d_all[gi]),
            .flag_q   (flag_q_all[gi]),
            .overrun  (overrun_all[gi])
         );
      end
   endgenerate

   assign request_flags_groups_4_5 = flag_q_all[15:0];
   assign request_flags_groups_6_7 = flag_q_all[31:16];

   // Present only flags whose source enable is set
   assign pend_45_d = flag_d_all[15:0] & source_enable_groups_4_5;
   assign pend_67_d = flag_d_all[31:16] & source_enable_groups_6_7;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending_groups_4_5 <= `FLAGS_RESET;
         pending_groups_6_7 <= `FLAGS_RESET;
      end
      else if (clk_en)
      begin
         pending_groups_4_5 <= pend_45_d;
         pending_groups_6_7 <= pend_67_d;
      end
   end

   // Events: newly presented request per word, request on an already set flag
   assign event_vec[`EVT_PEND_45] = |(pend_45_d & ~pending_groups_4_5);
   assign event_vec[`EVT_PEND_67] = |(pend_67_d & ~pending_groups_6_7);
   assign event_vec[`EVT_OVERRUN] = |overrun_all;

   assign status_w1c = (wr_fire & sel_status) ? pwdata[`EVT_W-1:0] : `INT_RESET;
   // New event wins over a clear in the same cycle
   assign status_d   = (status_q & ~status_w1c) | event_vec;
   assign mask_d     = (wr_fire & sel_mask) ? pwdata[`EVT_W-1:0] : mask_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_q <= `INT_RESET;
         mask_q   <= `INT_RESET;
         irq      <= 1'b0;
      end
      else if (clk_en)
      begin
         status_q <= status_d;
         mask_q   <= mask_d;
         irq      <= |(status_d & mask_d);
      end
   end

   // Read mux; reserved bits and write-only aliases read zero
   always @*
   begin
      rdata_d = 32'h0000_0000;
      case (1'b1)
         sel_flags_45:
         begin
            rdata_d[15:0] = flag_q_all[15:0];
         end
         sel_flags_67:
         begin
            rdata_d[15:0] = flag_q_all[31:16];
         end
         sel_flags_7:
         begin
            rdata_d[7:0] = flag_q_all[31:24];
         end
         sel_status:
         begin
            rdata_d[`EVT_W-1:0] = status_q;
         end
         sel_mask:
         begin
            rdata_d[`EVT_W-1:0] = mask_q;
         end
         default:
         begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // APB slave handshake with one wait state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (access_first)
         begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
         end
         else
         begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
         end
      end
   end

endmodule // request_flags_bank

// File: verif/cpu_accept_model.sv
// CPU side that accepts presented requests
`timescale 1ns/1ps
module cpu_accept_model (
   input wire        pclk,
   input wire        presetn,
   input wire        master_interrupt_enable,
   input wire [3:0]  delay,
   input wire [15:0] pending_a,
   input wire [15:0] pending_b,
   output reg [15:0] accept_a,
   output reg [15:0] accept_b
);
   reg [3:0] cnt_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 4'h0;
         accept_a <= 16'h0;
         accept_b <= 16'h0;
      end
      else
      begin
         accept_a <= 16'h0;
         accept_b <= 16'h0;
         // Takes nothing while disabled or a pulse is still out
         if (!master_interrupt_enable || (pending_a | pending_b) == 16'h0 ||
             (accept_a | accept_b) != 16'h0)
            cnt_q <= 4'h0;
         else if (cnt_q != delay)
            cnt_q <= cnt_q + 4'h1;
         else if (pending_a != 16'h0)
            accept_a <= pending_a & (~pending_a + 16'h1);
         else
            accept_b <= pending_b & (~pending_b + 16'h1);
      end
   end
endmodule // cpu_accept_model

// File: verif/flags_bank_chk.sv
// Assertions on the request flag bank ports
`timescale 1ns/1ps
`include "irq_flags_regs.vh"
module flags_bank_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        timer_four_request,
   input wire        timer_two_request,
   input wire        timer_x_request,
   input wire [15:0] source_enable_groups_4_5,
   input wire [15:0] accept_groups_4_5,
   input wire [15:0] request_flags_groups_4_5,
   input wire [15:0] request_flags_groups_6_7,
   input wire [15:0] pending_groups_4_5
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      clk_en && psel && !penable;
   endsequence
   sequence s_access;
      clk_en && psel && penable && !pready;
   endsequence
   chk_ready_time: assert property (s_setup ##1 s_access |=> pready)
      else $error("answer not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("data with slave error");
   chk_hw_set: assert property (clk_en && timer_four_request |=> request_flags_groups_4_5[14])
      else $error("timer four flag not set");
   chk_hwx_set: assert property (clk_en && timer_x_request |=> request_flags_groups_6_7[9])
      else $error("timer x flag not set");
   chk_pend_and: assert property (clk_en |=> pending_groups_4_5 ==
      (request_flags_groups_4_5 & $past(source_enable_groups_4_5)))
      else $error("pending not flag and enable");
   chk_accept_clr: assert property (clk_en && accept_groups_4_5[6] && !timer_two_request
      && !(psel && pwrite) |=> !request_flags_groups_4_5[6])
      else $error("flag kept after accept");
   chk_resv_45: assert property ((request_flags_groups_4_5 & ~`IMPL_45) == 16'h0)
      else $error("reserved bit set in word 45");
   chk_resv_67: assert property ((request_flags_groups_6_7 & ~`IMPL_67) == 16'h0)
      else $error("reserved bit set in word 67");
endmodule // flags_bank_chk
bind request_flags_bank flags_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_four_request(timer_four_request),
   .timer_two_request(timer_two_request), .timer_x_request(timer_x_request),
   .source_enable_groups_4_5(source_enable_groups_4_5), .accept_groups_4_5(accept_groups_4_5),
   .request_flags_groups_4_5(request_flags_groups_4_5),
   .request_flags_groups_6_7(request_flags_groups_6_7), .pending_groups_4_5(pending_groups_4_5));

// File: verif/request_flags_bank_bench.sv
// Self-checking bench of the request flag bank
`timescale 1ns/1ps
`include "irq_flags_regs.vh"
module request_flags_bank_bench;
   reg        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, master_en = 0;
   reg [17:0] paddr = 0;
   reg [31:0] pwdata = 0;
   reg [12:0] req = 0;
   reg [15:0] en45 = 0, en67 = 0, lfsr = 16'd95;
   reg [3:0]  dly = 0;
   wire [31:0] prdata;
   wire        pready, pslverr, irq;
   wire [15:0] f45, f67, p45, p67, a45, a67;
   integer     errors = 0, checks = 0, i;
   reg [33:0]  eq[$];
   int pos[13] = '{14, 9, 8, 7, 6, 2, 1, 0, 13, 12, 11, 10, 9};
   request_flags_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_four_request(req[0]),
      .uart_ch21_request(req[1]), .uart_ch20_request(req[2]), .timer_three_request(req[3]),
      .timer_two_request(req[4]), .uart_ch11_request(req[5]), .uart_ch10_request(req[6]),
      .i2c_unit_zero_request(req[7]), .slow_timebase_two_request(req[8]),
      .slow_timebase_one_request(req[9]), .slow_timebase_three_request(req[10]),
      .slow_timebase_zero_request(req[11]), .timer_x_request(req[12]),
      .source_enable_groups_4_5(en45), .source_enable_groups_6_7(en67),
      .accept_groups_4_5(a45), .accept_groups_6_7(a67), .request_flags_groups_4_5(f45),
      .request_flags_groups_6_7(f67), .pending_groups_4_5(p45), .pending_groups_6_7(p67),
      .irq(irq));
   cpu_accept_model cpu (.pclk(pclk), .presetn(presetn), .master_interrupt_enable(master_en),
      .delay(dly), .pending_a(p45), .pending_b(p67), .accept_a(a45), .accept_b(a67));
   initial forever #2 pclk = ~pclk;
   function [15:0] lfsr_next(input [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task conclude;
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input [31:0] s, input [31:0] e);
      checks++;
      if (s !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Expectation: {check data, error, data}
   task apb(input w, input [15:0] a, input [31:0] d, input [33:0] e);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1;
         pwrite <= w;
         paddr <= {a, 2'b00};
         pwdata <= d;
         eq.push_back(e);
         @(posedge pclk);
         penable <= 1;
         n = 0;
         do
         begin
            @(posedge pclk);
            n = n + 1;
         end
         while (pready !== 1'b1 && n < 20);
         psel <= 0;
         penable <= 0;
         if (n >= 20)
         begin
            errors++;
            conclude;
         end
      end
   endtask
   task rd(input [15:0] a, input [31:0] e);
      apb(0, a, 0, {2'b10, e});
   endtask
   task wr(input [15:0] a, input [31:0] d);
      apb(1, a, d, 34'h0);
   endtask
   task wt(input string n, input s, input [15:0] e);
      reg [15:0] v;
      integer k;
      begin
         for (k = 0; k < 16; k++)
         begin
            @(posedge pclk);
            v = s ? f45 : {15'h0, irq};
            if (v === e)
               break;
         end
         chk(n, v, e);
         if (v !== e)
            conclude;
      end
   endtask
   always @(posedge pclk)
   begin
      reg [33:0] e;
      if (pready === 1'b1)
      begin
         if (eq.size() == 0)
            chk("answer", 1, 0);
         else
         begin
            e = eq.pop_front();
            chk("pslverr", pslverr, e[32]);
            if (e[33])
               chk("prdata", prdata, e[31:0]);
         end
      end
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      errors++;
      conclude;
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      rd(`IDX_FLAGS_45, 0);
      rd(`IDX_FLAGS_67, 0);
      rd(`IDX_INT_MASK, 0);
      for (i = 0; i < 13; i++)
      begin
         @(posedge pclk) req <= 13'h1 << i;
         @(posedge pclk) req <= 0;
         rd(i < 8 ? `IDX_FLAGS_45 : `IDX_FLAGS_67, 32'h1 << pos[i]);
         chk("pending", {p45, p67}, 0);
         wr(i < 8 ? `IDX_CLR_45 : `IDX_CLR_67, 32'h1 << pos[i]);
      end
      for (i = 0; i < 8; i++)
      begin
         lfsr = lfsr_next(lfsr);
         wr(`IDX_FLAGS_45, {16'h0, lfsr});
         rd(`IDX_FLAGS_45, lfsr & `IMPL_45);
         wr(`IDX_FLAGS_67, {16'h0, ~lfsr});
         rd(`IDX_FLAGS_67, ~lfsr & `IMPL_67);
      end
      wr(`IDX_FLAGS_67, 0);
      wr(`IDX_SET_67, 32'hffff);
      rd(`IDX_FLAGS_7, 32'h3e);
      wr(`IDX_FLAGS_45, 0);
      wr(`IDX_SET_45, 32'h4000);
      wr(`IDX_SET_45, 32'h1);
      rd(`IDX_FLAGS_45, 32'h4001);
      wr(`IDX_CLR_45, 32'h4000);
      rd(`IDX_FLAGS_45, 32'h1);
      apb(1, 16'h0, 32'hffff, {2'b01, 32'h0});
      apb(0, 16'h0, 0, {2'b11, 32'h0});
      wr(`IDX_FLAGS_45, 0);
      wr(`IDX_FLAGS_67, 0);
      wr(`IDX_INT_STATUS, 7);
      wr(`IDX_INT_MASK, 7);
      @(posedge pclk) en45 <= 16'hffff;
      dly <= 3;
      wr(`IDX_SET_45, 32'h40);
      rd(`IDX_FLAGS_45, 32'h40);
      chk("pending45", p45, 16'h40);
      wt("irq", 0, 1);
      @(posedge pclk) req <= 13'h10;
      @(posedge pclk) req <= 0;
      wr(`IDX_INT_MASK, 0);
      wt("irq", 0, 0);
      rd(`IDX_INT_STATUS, 5);
      wr(`IDX_INT_MASK, 7);
      wt("irq", 0, 1);
      wr(`IDX_INT_STATUS, 5);
      wt("irq", 0, 0);
      @(posedge pclk) master_en <= 1;
      wt("flags45", 1, 0);
      dly <= 0;
      @(posedge pclk) req <= 13'h1;
      @(posedge pclk) req <= 0;
      wt("flags45", 1, 0);
      @(posedge pclk) en67 <= 16'hffff;
      req <= 13'h1000;
      @(posedge pclk) req <= 0;
      @(posedge pclk) chk("pending67", p67, 16'h0200);
      rd(`IDX_FLAGS_67, 0);
      rd(`IDX_INT_STATUS, 3);
      @(posedge pclk) presetn <= 0;
      @(posedge pclk) presetn <= 1;
      chk("irq", irq, 0);
      rd(`IDX_INT_STATUS, 0);
      rd(`IDX_INT_MASK, 0);
      conclude;
   end
endmodule // request_flags_bank_bench
